// ### design/wtp_defines.vh
// constants for the watchdog and address trap supervisor
`ifndef WTP_DEFINES_VH
`define WTP_DEFINES_VH
`define WTP_OFS_CTRL      12'h0D0
`define WTP_OFS_CMD       12'h0D4
`define WTP_OFS_STATUS    12'h0D8
`define WTP_OFS_MASK      12'h0DC
`define WTP_OFS_CFG       12'h0E0
`define WTP_OFS_STATE     12'h0E4
`define WTP_IDX_CTRL      8'h34
`define WTP_IDX_CMD       8'h35
`define WTP_CODE_CLEAR    8'h4E
`define WTP_CODE_DISABLE  8'hB1
`define WTP_CODE_TRAP     8'hD2
`define WTP_BIT_OUTSEL    0
`define WTP_BIT_PERIOD_LO 1
`define WTP_BIT_PERIOD_HI 2
`define WTP_BIT_ENABLE    3
`define WTP_BIT_TRAPSEL   4
`define WTP_BIT_RAMTRAP   5
`define WTP_CTRL_RESET    8'h39
`define WTP_ST_WDT        0
`define WTP_ST_TRAP       1
`define WTP_ST_RST        2
`define WTP_RST_TIME_NS   960
`define WTP_CLK_NS        40
`endif

// ### design/wtp_range_det.v
// fetch address range detector for the address trap
`timescale 1ns/1ps
module wtp_range_det #(
   parameter AW = 16
) (
   input  wire [AW-1:0] i_addr,
   input  wire [AW-1:0] i_lo,
   input  wire [AW-1:0] i_hi,
   output wire          o_hit
);
   assign o_hit = (i_addr >= i_lo) && (i_addr <= i_hi);
endmodule // wtp_range_det

// ### design/wtp_supervisor.v
// watchdog reset and address trap supervisor with AHB-Lite registers
`timescale 1ns/1ps
`include "wtp_defines.vh"
// Operation
// [R1] watchdog overflow with output select 1 requests a system reset
// [R2] internal reset pulse lasts at most 24 high-frequency clock periods
// [R3] reset in low-speed mode restarts the high-frequency oscillator
// [R4] command code 4EH clears watchdog counter; undefined codes do nothing
// [R5] command code B1H disables the watchdog
// [R6] RAM trap enable takes effect only after command code D2H
// [R7] fetches from special-function or data-buffer areas always trap
// [R8] trap action select picks interrupt or reset for a trap
// [R9] trap action 0 with a trapped fetch raises the trap interrupt
// [R10] trap interrupt is non-maskable, ignores interrupt master flag
// [R11] trap during other interrupt service is taken at once
// [R12] software sets stack pointer first and avoids deep trap nesting
// [R13] trap action 1 with a trapped fetch resets all hardware
// [R14] watchdog and trap logic share the two control ports
// [R15] command port is write-only with undefined initial content
// [R16] control port write-only; bit 5 RAM trap enable, bit 4 trap action
// [R17] disable code honoured only while watchdog enable bit is 0
// [R18] cleared overflow select cannot be set again until reset
// [R19] trap areas are parameterised address ranges
module wtp_supervisor #(
   parameter        AW       = 16,
   parameter        CNT_W    = 26,
   parameter [15:0] RAM_LO   = 16'h0040,
   parameter [15:0] RAM_HI   = 16'h083F,
   parameter [15:0] SFR_LO   = 16'h0000,
   parameter [15:0] SFR_HI   = 16'h003F,
   parameter [15:0] DBR_LO   = 16'h0F00,
   parameter [15:0] DBR_HI   = 16'h0FFF
) (
   input  wire          i_core_clk,
   input  wire          i_rst_b,
   input  wire          i_hsel,
   input  wire [31:0]   i_haddr,
   input  wire [1:0]    i_htrans,
   input  wire          i_hwrite,
   input  wire [2:0]    i_hsize,
   input  wire [31:0]   i_hwdata,
   input  wire          i_hready,
   output reg  [31:0]   o_hrdata,
   output wire          o_hreadyout,
   output wire          o_hresp,
   input  wire          i_fetch_valid,
   input  wire [AW-1:0] i_fetch_addr,
   input  wire          i_low_speed_single_clock_mode,
   input  wire          i_irq_busy,
   output wire          o_irq,
   output reg           o_address_trap_irq,
   output reg           o_watchdog_irq,
   output reg           o_sys_reset,
   output reg           o_hf_osc_restart
);
   localparam RST_CYC = `WTP_RST_TIME_NS / `WTP_CLK_NS;
   localparam [4:0] RST_LEN = RST_CYC[4:0];

   reg  [7:0]       ctrl_ff;
   reg              ram_trap_act_ff;
   reg  [CNT_W-1:0] cnt_ff;
   reg  [2:0]       status_ff;
   reg  [2:0]       mask_ff;
   reg  [4:0]       rst_cnt_ff;
   reg              ap_wr_ff;
   reg              ap_rd_ff;
   reg  [11:0]      ap_addr_ff;
   wire             hit_ram;
   wire             hit_sfr;
   wire             hit_dbr;
   wire             trap;
   wire             ovf;
   wire             wr_ctrl;
   wire             wr_cmd;
   wire             wr_stat;
   wire             wr_mask;
   wire [CNT_W-1:0] limit;
   wire [7:0]       wb;
   wire             ap_go;

   // register index to byte address; both print forms map the same word
   function is_addr;
      input [11:0] a;
      input [11:0] ofs;
      input [7:0]  idx;
      begin
         is_addr = (a == ofs) || (a == {2'h0, idx, 2'h0});
      end
   endfunction

   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign ap_go = i_hsel && i_hready && i_htrans[1];
   assign wb    = i_hwdata[7:0];

   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ap_wr_ff   <= 1'b0;
         ap_rd_ff   <= 1'b0;
         ap_addr_ff <= 12'h000;
      end else begin
         ap_wr_ff   <= ap_go && i_hwrite;
         ap_rd_ff   <= ap_go && !i_hwrite;
         ap_addr_ff <= i_haddr[11:0];
      end
   end

   // control and command share the two ports of both functions, see [R14]
   assign wr_ctrl = ap_wr_ff &&
                    is_addr(ap_addr_ff, `WTP_OFS_CTRL, `WTP_IDX_CTRL);
   assign wr_cmd  = ap_wr_ff &&
                    is_addr(ap_addr_ff, `WTP_OFS_CMD, `WTP_IDX_CMD);
   assign wr_stat = ap_wr_ff && (ap_addr_ff == `WTP_OFS_STATUS);
   assign wr_mask = ap_wr_ff && (ap_addr_ff == `WTP_OFS_MASK);

   wtp_range_det #(.AW(AW)) u_ram (
      .i_addr (i_fetch_addr),
      .i_lo   (RAM_LO[AW-1:0]),
      .i_hi   (RAM_HI[AW-1:0]),
      .o_hit  (hit_ram)
   ); // see [R19]
   wtp_range_det #(.AW(AW)) u_sfr (
      .i_addr (i_fetch_addr),
      .i_lo   (SFR_LO[AW-1:0]),
      .i_hi   (SFR_HI[AW-1:0]),
      .o_hit  (hit_sfr)
   );
   wtp_range_det #(.AW(AW)) u_dbr (
      .i_addr (i_fetch_addr),
      .i_lo   (DBR_LO[AW-1:0]),
      .i_hi   (DBR_HI[AW-1:0]),
      .o_hit  (hit_dbr)
   );

   // ram only with the committed enable; sfr and dbr always, see [R7]
   assign trap = i_fetch_valid &&
                 ((hit_ram && ram_trap_act_ff) || hit_sfr || hit_dbr);

   // period select: 2^26, 2^24, 2^22, 2^20 cycles, scaled to counter width
   assign limit = {CNT_W{1'b1}} >>
                  {ctrl_ff[`WTP_BIT_PERIOD_HI:`WTP_BIT_PERIOD_LO], 1'b0};
   assign ovf = ctrl_ff[`WTP_BIT_ENABLE] && (cnt_ff >= limit);

   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_ff         <= `WTP_CTRL_RESET;
         ram_trap_act_ff <= 1'b0;
         cnt_ff          <= {CNT_W{1'b0}};
      end else begin
         if (wr_ctrl) begin
            // output select can only fall, see [R18]
            ctrl_ff <= {wb[7:1], wb[`WTP_BIT_OUTSEL] &
                                 ctrl_ff[`WTP_BIT_OUTSEL]}; // see [R16]
         end
         // undefined codes fall through with no effect, see [R4]
         if (wr_cmd && wb == `WTP_CODE_TRAP) begin
            ram_trap_act_ff <= ctrl_ff[`WTP_BIT_RAMTRAP]; // see [R6]
         end
         if (!ctrl_ff[`WTP_BIT_ENABLE]) begin
            cnt_ff <= {CNT_W{1'b0}};
         end else if (wr_cmd && wb == `WTP_CODE_CLEAR) begin
            cnt_ff <= {CNT_W{1'b0}}; // see [R4]
         end else if (ovf) begin
            cnt_ff <= {CNT_W{1'b0}};
         end else begin
            cnt_ff <= cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
         end
         // disable code only with enable already 0, see [R5] [R17]
         if (wr_cmd && wb == `WTP_CODE_DISABLE &&
             !ctrl_ff[`WTP_BIT_ENABLE]) begin
            cnt_ff <= {CNT_W{1'b0}};
         end
      end
   end

   wire wdt_rst_req  = ovf && ctrl_ff[`WTP_BIT_OUTSEL];            // see [R1]
   wire wdt_irq_req  = ovf && !ctrl_ff[`WTP_BIT_OUTSEL];
   wire trap_rst_req = trap && ctrl_ff[`WTP_BIT_TRAPSEL]; // see [R8] [R13]
   wire trap_irq_req = trap && !ctrl_ff[`WTP_BIT_TRAPSEL];        // see [R9]
   wire rst_req      = wdt_rst_req || trap_rst_req;

   // reset pulse held for a fixed count; own reset leaves counter alone
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rst_cnt_ff       <= 5'h00;
         o_sys_reset      <= 1'b0;
         o_hf_osc_restart <= 1'b0;
      end else begin
         if (rst_req && rst_cnt_ff == 5'h00) begin
            rst_cnt_ff  <= RST_LEN;                              // see [R2]
            o_sys_reset <= 1'b1;
            // oscillator restart makes the pulse approximate, see [R3]
            o_hf_osc_restart <= i_low_speed_single_clock_mode;
         end else if (rst_cnt_ff != 5'h00) begin
            rst_cnt_ff  <= rst_cnt_ff - 5'h01;
            o_sys_reset <= (rst_cnt_ff != 5'h01);
            if (rst_cnt_ff == 5'h01) begin
               o_hf_osc_restart <= 1'b0;
            end
         end
      end
   end

   // nmi pulse ignores master flag and in-service state, see [R10] [R11]
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_address_trap_irq <= 1'b0;
         o_watchdog_irq     <= 1'b0;
      end else begin
         o_address_trap_irq <= trap_irq_req;
         o_watchdog_irq     <= wdt_irq_req;
      end
   end

   // sticky status; a new event wins over a write-one clear
   wire [2:0] ev  = {rst_req, trap, ovf};
   wire [2:0] clr = wr_stat ? i_hwdata[2:0] : 3'h0;
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         status_ff <= 3'h0;
         mask_ff   <= 3'h0;
      end else begin
         status_ff <= (status_ff & ~clr) | ev;
         if (wr_mask) begin
            mask_ff <= i_hwdata[2:0];
         end
      end
   end
   assign o_irq = |(status_ff & mask_ff);

   // control and command ports read as zero: write-only, see [R16]
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_hrdata <= 32'h00000000;
      end else if (ap_go && !i_hwrite) begin
         case (i_haddr[11:0])
            `WTP_OFS_STATUS: o_hrdata <= {29'h0, status_ff};
            `WTP_OFS_MASK:   o_hrdata <= {29'h0, mask_ff};
            `WTP_OFS_STATE:  o_hrdata <= {31'h0, ram_trap_act_ff};
            `WTP_OFS_CFG:    o_hrdata <= {24'h0, ctrl_ff};
            default:         o_hrdata <= 32'h00000000;
         endcase
      end
   end
endmodule // wtp_supervisor

// ### testbench/wtp_supervisor_checker.sv
// port assertions for the watchdog and trap supervisor
`timescale 1ns/1ps
module wtp_chk #(
   parameter        AW     = 16,
   parameter [15:0] SFR_HI = 16'h003F,
   parameter [15:0] DBR_LO = 16'h0F00,
   parameter [15:0] DBR_HI = 16'h0FFF
) (
   input wire          i_core_clk,
   input wire          i_rst_b,
   input wire          i_fetch_valid,
   input wire [AW-1:0] i_fetch_addr,
   input wire          o_hreadyout,
   input wire          o_hresp,
   input wire          o_address_trap_irq,
   input wire          o_sys_reset,
   input wire          o_hf_osc_restart
);
   reg  [4:0] rst_cnt_ff;
   // special area starts at zero, so only its top bound is compared
   wire       area_hit = i_fetch_valid && (i_fetch_addr <= SFR_HI ||
                 (i_fetch_addr >= DBR_LO && i_fetch_addr <= DBR_HI));
   always @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         rst_cnt_ff <= 5'h00;
      else
         rst_cnt_ff <= o_sys_reset ? rst_cnt_ff + 5'h01 : 5'h00;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   sequence trap_fetch_s; area_hit && !o_sys_reset; endsequence
   sequence trap_taken_s; o_address_trap_irq || o_sys_reset; endsequence
   ready_high_a: assert property (o_hreadyout)
      else $error("slave inserted a wait state");
   resp_okay_a: assert property (!o_hresp)
      else $error("slave answered with an error");
   area_trap_a: assert property (trap_fetch_s |=> trap_taken_s)
      else $error("area fetch not trapped");
   trap_cause_a: assert property (
      o_address_trap_irq |-> $past(i_fetch_valid))
      else $error("trap interrupt without a fetch");
   one_action_a: assert property (
      o_address_trap_irq |-> !$rose(o_sys_reset))
      else $error("trap gave interrupt and reset");
   rst_len_a: assert property (
      $fell(o_sys_reset) |-> rst_cnt_ff == 5'd24)
      else $error("reset pulse length wrong");
   rst_hold_a: assert property (
      $rose(o_sys_reset) |-> o_sys_reset[*8])
      else $error("reset pulse too short");
   osc_in_rst_a: assert property (o_hf_osc_restart |-> o_sys_reset)
      else $error("oscillator restart outside reset");
endmodule // wtp_chk
bind wtp_supervisor wtp_chk #(.AW(AW), .SFR_HI(SFR_HI), .DBR_LO(DBR_LO),
   .DBR_HI(DBR_HI)) wtp_chk_i (.i_core_clk, .i_rst_b, .i_fetch_valid,
   .i_fetch_addr, .o_hreadyout, .o_hresp, .o_address_trap_irq,
   .o_sys_reset, .o_hf_osc_restart);

// ### testbench/wtp_fetch_model.sv
// instruction fetch model standing in for the cpu core
`timescale 1ns/1ps
module wtp_fetch_model (
   input  wire        i_clk,
   output reg         o_valid,
   output reg  [15:0] o_addr
);
   initial begin
      o_valid = 1'b0;
      o_addr  = 16'h0000;
   end
   // one fetch a call, never nested; address inverted so nothing lingers
   task fetch(input logic [15:0] a);
      o_valid <= 1'b1;
      o_addr  <= a;
      @(posedge i_clk);
      o_valid <= 1'b0;
      o_addr  <= ~a;
   endtask
endmodule // wtp_fetch_model

// ### testbench/testbench.sv
// self-checking bench for the watchdog and trap supervisor
`timescale 1ns/1ps
module testbench;
   logic        clk, rst_b, hsel, hwrite, lsm, busy;
   logic [31:0] haddr, hwdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire  [31:0] hrdata;
   wire  [15:0] fa;
   wire         fv, rdy, resp, irq, tirq, wirq, srst, osc;
   integer      mismatches = 0, comparisons = 0;
   wtp_supervisor #(.CNT_W(8)) wtp_supervisor_i (
      .i_core_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
      .o_hreadyout(rdy), .o_hresp(resp), .i_fetch_valid(fv),
      .i_fetch_addr(fa), .i_low_speed_single_clock_mode(lsm),
      .i_irq_busy(busy), .o_irq(irq), .o_address_trap_irq(tirq),
      .o_watchdog_irq(wirq), .o_sys_reset(srst), .o_hf_osc_restart(osc));
   wtp_fetch_model wtp_fetch_model_i (.i_clk(clk), .o_valid(fv), .o_addr(fa));
   task final_report;
      if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task bus(input logic w, input logic [31:0] a, d);
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task wr(input logic [31:0] a, d);
      bus(1'b1, a, d);
   endtask
   task ftrap(input logic [15:0] a, input logic e);
      wtp_fetch_model_i.fetch(a);
      #1 chk("trap_irq", e, tirq);
   endtask
   // counts the cycles the reset output stays high
   task rst_len;
      int n;
      n = 0;
      while (srst === 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      chk("reset_len", 24, n);
   endtask
   task t_wdt_reset;
      int n;
      n = 0;
      while (srst !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
      end
      chk("osc_restart", 1, osc);
      rst_len;
   endtask
   // 300 cycles exceeds the 255 cycle limit, so only the enable bit cleared by the control write keeps it quiet
   task t_disable;
      lsm <= 1'b0;
      wr(32'hD8, 32'h07);
      wr(32'hD4, 32'h4E);
      repeat (150) @(posedge clk);
      wr(32'hD4, 32'h4E);
      repeat (150) @(posedge clk);
      wr(32'hD4, 32'h55);
      wr(32'hD0, 32'h01);
      wr(32'hD4, 32'hB1);
      repeat (300) @(posedge clk);
      bus(1'b0, 32'hD8, 0);
      chk("wdt_quiet", 0, rd[2:0]);
   endtask
   task t_ram_trap;
      wr(32'hD0, 32'h21);
      ftrap(16'h0100, 1'b0);
      wr(32'hD4, 32'hD2);
      ftrap(16'h0100, 1'b1);
      bus(1'b0, 32'hE4, 0);
      chk("ram_trap_on", 1, rd[0]);
   endtask
   task t_trap_irq;
      busy <= 1'b1;
      wr(32'hD8, 32'h07);
      wr(32'hDC, 32'h00);
      ftrap(16'h0010, 1'b1);
      ftrap(16'h0F80, 1'b1);
      chk("irq_masked", 0, irq);
      wr(32'hDC, 32'h02);
      #1 chk("irq_level", 1, irq);
      wr(32'hD8, 32'h02);
      #1 chk("irq_cleared", 0, irq);
      busy <= 1'b0;
   endtask
   task t_trap_reset;
      wr(32'hD0, 32'h11);
      ftrap(16'h0020, 1'b0);
      chk("trap_rst", 1, srst);
      chk("osc_restart", 0, osc);
      rst_len;
   endtask
   task t_lock;
      int n;
      logic seen, rst_seen;
      wr(32'hD0, 32'h00);
      wr(32'hD0, 32'h01);
      bus(1'b0, 32'hE0, 0);
      chk("outsel_lock", 0, rd[0]);
      bus(1'b0, 32'h100, 0);
      chk("unmapped_rd", 0, rd);
      // re-enable with output select locked low: overflow gives interrupt
      wr(32'hD0, 32'h09);
      n = 0;
      seen = 1'b0;
      rst_seen = 1'b0;
      while (seen !== 1'b1 && n < 400) begin
         @(posedge clk);
         #1 n++;
         if (wirq === 1'b1) seen = 1'b1;
         if (srst === 1'b1) rst_seen = 1'b1;
      end
      chk("wdt_irq", 1, seen);
      chk("wdt_no_reset", 0, rst_seen);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      #400000 mismatches++;
      final_report;
   end
   initial begin
      rst_b = 1'b0;
      hsel = 1'b1;
      hsize = 3'b010;
      htrans = 2'b00;
      haddr = 32'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      lsm = 1'b1;
      busy = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_wdt_reset;
      t_disable;
      t_ram_trap;
      t_trap_irq;
      t_trap_reset;
      t_lock;
      final_report;
   end
endmodule // testbench
